// [arnf_defs.vh]
// Constants for the asynchronous request node filter.
`ifndef ARNF_DEFS_VH
`define ARNF_DEFS_VH
`define ARNF_ADDR_W        12
`define ARNF_OFS_HI_SET    12'h0100
`define ARNF_OFS_HI_CLR    12'h0104
`define ARNF_OFS_LO_SET    12'h0108
`define ARNF_OFS_LO_CLR    12'h010C
`define ARNF_OFS_STATUS    12'h0180
`define ARNF_FILTER_RST    32'h0000_0000
`define ARNF_ALL_BUS_BIT   5'h1F
`define ARNF_LOCAL_BUS     10'h3FF
`define ARNF_UPPER_BASE    6'h20
`define ARNF_BROADCAST     6'h3F
`define ARNF_CNT_W         16
`define ARNF_CNT_ONE       16'h0001
`define ARNF_CNT_RST       16'h0000
`define ARNF_RDATA_IDLE    32'h0000_0000
`endif

// [arnf_filter_reg.v]
// One set/clear filter register with read-back.
`timescale 1ns/1ps
`default_nettype none
`include "arnf_defs.vh"
module arnf_filter_reg (
  // Clock and reset.
  input  wire        clk_i,
  input  wire        rst_n_i,
  // Set and clear strobes with their data.
  input  wire        set_i,
  input  wire        clr_i,
  input  wire [31:0] wdata_i,
  // Current contents.
  output reg  [31:0] filter_o
);
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      filter_o <= `ARNF_FILTER_RST;
    else if (set_i)
      filter_o <= filter_o | wdata_i;
    else if (clr_i)
      filter_o <= filter_o & ~wdata_i;
  end
endmodule // arnf_filter_reg
`default_nettype wire

// [arnf_match.v]
// Combinational acceptance decision for one source node identifier.
`timescale 1ns/1ps
`default_nettype none
`include "arnf_defs.vh"
module arnf_match (
  // Filter contents.
  input  wire [31:0] upper_i,
  input  wire [31:0] lower_i,
  // Local identity and packet source.
  input  wire [9:0]  local_bus_i,
  input  wire [15:0] src_id_i,
  // Decision.
  output reg         accept_o
);
  reg [5:0] node;
  reg [9:0] bus;
  reg       same_bus;
  always @*
  begin
    node     = src_id_i[5:0];
    bus      = src_id_i[15:6];
    same_bus = (bus == local_bus_i) || (bus == `ARNF_LOCAL_BUS);
    if (!same_bus)
      accept_o = upper_i[`ARNF_ALL_BUS_BIT];
    else if (node == `ARNF_BROADCAST)
      accept_o = 1'b0;
    else if (node[5])
      accept_o = upper_i[node[4:0]];
    else
      accept_o = lower_i[node[4:0]];
  end
endmodule // arnf_match
`default_nettype wire

// [arnf_top.v]
// Asynchronous request node filter: registers, decision and counters.
// Functional notes
// - Each received request for the physical or request-queue context is checked by source.
// - A request whose source bit is clear is not acknowledged and not queued.
// - The per-node bit comparison applies only to sources on the local bus.
// - Remote-bus requests are accepted only while bit 31 of the upper filter is set.
// - Upper filter bit k admits local node k plus 32 for k from 0 to 30.
// - Ones written at a set address set bits, ones at a clear address clear them.
// - Reset clears every filter bit so nothing is accepted.
// - A lower filter admits local nodes 0 to 31 with its own set and clear addresses.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "arnf_defs.vh"
module arnf_top (
  // Clock and reset.
  input  wire        CORE_CLK_I,
  input  wire        RST_N_I,
  // Register port.
  input  wire [11:0] ADDR_I,
  input  wire [31:0] WDATA_I,
  input  wire        WR_I,
  input  wire        RD_I,
  output reg  [31:0] RDATA_O,
  // Local identity.
  input  wire [9:0]  LOCAL_BUS_I,
  // Received request for checking.
  input  wire        PKT_VALID_I,
  input  wire [15:0] PKT_SRC_ID_I,
  // Decision, one cycle later.
  output reg         PKT_DONE_O,
  output reg         PKT_ACK_O,
  output reg         PKT_QUEUE_O
);
  // Filter contents and the decision for the request on the port.
  wire [31:0] upper;
  wire [31:0] lower;
  wire        accept;

  // Decoded register strobes.
  wire        upper_set;
  wire        upper_clr;
  wire        lower_set;
  wire        lower_clr;
  wire        read_upper;
  wire        read_lower;
  wire        read_status;

  // Request outcome in the cycle the request is presented.
  wire        take;
  wire        drop;

  // Accepted and rejected request counters for the status word.
  reg  [15:0] acc_cnt;
  reg  [15:0] rej_cnt;

  // Next values of the registered outputs and counters.
  reg         next_done;
  reg         next_ack;
  reg         next_queue;
  reg  [15:0] next_acc_cnt;
  reg  [15:0] next_rej_cnt;
  reg  [31:0] next_rdata;

  // True when the register port address selects the given offset.
  function hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // True when the address selects either alias of one filter.
  function hit_pair;
    input [11:0] a;
    input [11:0] ofs_set;
    input [11:0] ofs_clr;
    begin
      hit_pair = hit(a, ofs_set) || hit(a, ofs_clr);
    end
  endfunction

  // One step of a wrapping event counter.
  function [15:0] bump;
    input [15:0] cnt;
    begin
      bump = cnt + `ARNF_CNT_ONE;
    end
  endfunction

  // Register decode; the master never raises both strobes at once.
  assign upper_set   = WR_I && hit(ADDR_I, `ARNF_OFS_HI_SET);
  assign upper_clr   = WR_I && hit(ADDR_I, `ARNF_OFS_HI_CLR);
  assign lower_set   = WR_I && hit(ADDR_I, `ARNF_OFS_LO_SET);
  assign lower_clr   = WR_I && hit(ADDR_I, `ARNF_OFS_LO_CLR);
  assign read_upper  = RD_I && hit_pair(ADDR_I, `ARNF_OFS_HI_SET, `ARNF_OFS_HI_CLR);
  assign read_lower  = RD_I && hit_pair(ADDR_I, `ARNF_OFS_LO_SET, `ARNF_OFS_LO_CLR);
  assign read_status = RD_I && hit(ADDR_I, `ARNF_OFS_STATUS);

  // Outcome of the request presented in this cycle.
  assign take = PKT_VALID_I && accept;
  assign drop = PKT_VALID_I && !accept;

  arnf_filter_reg u_upper (
    .clk_i    (CORE_CLK_I),
    .rst_n_i  (RST_N_I),
    .set_i    (upper_set),
    .clr_i    (upper_clr),
    .wdata_i  (WDATA_I),
    .filter_o (upper)
  );

  arnf_filter_reg u_lower (
    .clk_i    (CORE_CLK_I),
    .rst_n_i  (RST_N_I),
    .set_i    (lower_set),
    .clr_i    (lower_clr),
    .wdata_i  (WDATA_I),
    .filter_o (lower)
  );

  arnf_match u_match (
    .upper_i     (upper),
    .lower_i     (lower),
    .local_bus_i (LOCAL_BUS_I),
    .src_id_i    (PKT_SRC_ID_I),
    .accept_o    (accept)
  );

  // Acknowledge and queue always travel together: a refused request gets neither.
  always @*
  begin
    next_done  = PKT_VALID_I;
    next_ack   = take;
    next_queue = take;
  end

  // Counters wrap silently; software reads them as a coarse activity gauge only.
  always @*
  begin
    next_acc_cnt = acc_cnt;
    next_rej_cnt = rej_cnt;
    if (take)
      next_acc_cnt = bump(acc_cnt);
    if (drop)
      next_rej_cnt = bump(rej_cnt);
  end

  // Read data stand for one cycle only and are zero otherwise.
  always @*
  begin
    next_rdata = `ARNF_RDATA_IDLE;
    if (read_upper)
      next_rdata = upper;
    else if (read_lower)
      next_rdata = lower;
    else if (read_status)
      next_rdata = {rej_cnt, acc_cnt};
  end

  // Decision uses the filter as it stands before any write in the same cycle.
  always @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      PKT_DONE_O  <= 1'b0;
      PKT_ACK_O   <= 1'b0;
      PKT_QUEUE_O <= 1'b0;
    end
    else
    begin
      PKT_DONE_O  <= next_done;
      PKT_ACK_O   <= next_ack;
      PKT_QUEUE_O <= next_queue;
    end
  end

  always @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      acc_cnt <= `ARNF_CNT_RST;
      rej_cnt <= `ARNF_CNT_RST;
    end
    else
    begin
      acc_cnt <= next_acc_cnt;
      rej_cnt <= next_rej_cnt;
    end
  end

  always @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      RDATA_O <= `ARNF_RDATA_IDLE;
    else
      RDATA_O <= next_rdata;
  end
endmodule // arnf_top
`default_nettype wire

// [arnf_node_model.sv]
// Far-side node model that presents requests chosen by the bench.
`timescale 1ns/1ps
`default_nettype none
module arnf_node_model (
  input  wire logic        clk_i,
  input  wire logic        send_i,
  input  wire logic [15:0] id_i,
  output var  logic        valid_o,
  output var  logic [15:0] src_o
);
  logic [15:0] last;
  // Idle source lines invert each cycle, so a stale id shows again on every second idle cycle.
  always_comb valid_o = send_i;
  always_comb src_o = send_i ? id_i : ~last;
  always @(posedge clk_i) last <= src_o;
endmodule // arnf_node_model
`default_nettype wire

// [arnf_top_properties.sv]
// Port checker for the request node filter.
`timescale 1ns/1ps
`default_nettype none
module arnf_top_chk (
  input wire logic        CORE_CLK_I, RST_N_I, WR_I, RD_I, PKT_VALID_I,
  input wire logic        PKT_DONE_O, PKT_ACK_O, PKT_QUEUE_O,
  input wire logic [11:0] ADDR_I,
  input wire logic [31:0] WDATA_I, RDATA_O,
  input wire logic [9:0]  LOCAL_BUS_I,
  input wire logic [15:0] PKT_SRC_ID_I
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  wire rem = PKT_SRC_ID_I[15:6] != LOCAL_BUS_I && PKT_SRC_ID_I[15:6] != 10'h3FF;
  wire n32 = !rem && PKT_SRC_ID_I[5:0] == 6'h20;
  a_done_follows: assert property (PKT_VALID_I |=> PKT_DONE_O) else $error("done missing");
  a_no_stray: assert property (!PKT_VALID_I |=> !PKT_DONE_O) else $error("stray done");
  a_queue_ack: assert property (PKT_QUEUE_O == PKT_ACK_O) else $error("queue differs");
  a_ack_done: assert property (PKT_ACK_O |-> PKT_DONE_O) else $error("ack alone");
  a_bcast_drop: assert property (PKT_VALID_I && !rem && PKT_SRC_ID_I[5:0] == 6'h3F |=> !PKT_ACK_O)
    else $error("node 63 taken");
  a_remote_set: assert property (WR_I && ADDR_I == 12'h100 && WDATA_I[31] ##1 PKT_VALID_I && rem
    |=> PKT_ACK_O) else $error("remote refused");
  a_remote_clr: assert property (WR_I && ADDR_I == 12'h104 && WDATA_I[31] ##1 PKT_VALID_I && rem
    |=> !PKT_ACK_O) else $error("remote taken");
  a_node_set: assert property (WR_I && ADDR_I == 12'h100 && WDATA_I[0] ##1 PKT_VALID_I && n32
    |=> PKT_ACK_O) else $error("node 32 refused");
  a_node_clr: assert property (WR_I && ADDR_I == 12'h104 && WDATA_I[0] ##1 PKT_VALID_I && n32
    |=> !PKT_ACK_O) else $error("node 32 taken");
  a_read_alias: assert property (RD_I && ADDR_I == 12'h100 ##1 RD_I && ADDR_I == 12'h104
    |=> RDATA_O == $past(RDATA_O)) else $error("set and clear reads differ");
endmodule // arnf_top_chk
bind arnf_top arnf_top_chk chk (.*);
`default_nettype wire

// [tb_arnf_top.sv]
// Self-checking bench for the request node filter.
`timescale 1ns/1ps
`default_nettype none
module tb_arnf_top;
  localparam logic [11:0] AT [6] = '{12'h100, 12'h104, 12'h108, 12'h10C, 12'h180, 12'h0FC};
  localparam logic [5:0]  NT [6] = '{6'd0, 6'd31, 6'd32, 6'd33, 6'd62, 6'd63};
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, send = 0, valid, done, ack, que;
  logic [11:0] addr = 0, a;
  logic [31:0] wdata = 0, rdata, d, hi = 0, lo = 0, erd = 0;
  logic [9:0]  lbus = 0, b;
  logic [15:0] id = 0, src, s;
  logic [2:0]  e3 = 0;
  int fails = 0, tests_run = 0, na = 0, nr = 0, op;
  bit pk;
  arnf_top dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .LOCAL_BUS_I(lbus), .PKT_VALID_I(valid), .PKT_SRC_ID_I(src),
    .PKT_DONE_O(done), .PKT_ACK_O(ack), .PKT_QUEUE_O(que));
  arnf_node_model node (.clk_i(clk), .send_i(send), .id_i(id), .valid_o(valid), .src_o(src));
  task chk(input logic [34:0] got, input logic [34:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic bit acc(input logic [15:0] v);
    if (v[15:6] != lbus && v[15:6] != 10'h3FF) return hi[31];
    if (v[5:0] == 6'h3F) return 1'b0;
    return v[5] ? hi[v[4:0]] : lo[v[4:0]];
  endfunction
  task end_sim;
    $display("mismatches %0d comparisons %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial forever #10 clk = ~clk;
  initial
  begin
    void'($urandom(32'hc454));
    repeat (16) @(posedge clk) lbus <= 10'($urandom);
    for (int i = 0; i < 4000; i++)
    begin
      @(posedge clk);
      op = $urandom % 3;
      a = AT[$urandom % 6];
      d = $urandom;
      pk = $urandom;
      b = ($urandom % 3 == 0) ? 10'h3FF : ($urandom % 2 ? lbus : 10'($urandom));
      s = {b, NT[$urandom % 6]};
      rst_n <= (i != 2000);
      if (i == 2000)
      begin
        {hi, lo, na, nr, erd, e3, op, pk} = 0;
        op = 2;
      end
      wr <= op == 0;
      rd <= op == 1;
      addr <= a;
      wdata <= d;
      send <= pk;
      id <= s;
      #1 chk({3'b0, rdata}, {3'b0, erd});
      chk({done, ack, que, 32'h0}, {e3, 32'h0});
      e3 = {pk, {2{pk && acc(s)}}};
      erd = 0;
      if (op == 1)
        erd = a[11:3] == 9'h020 ? hi : a[11:3] == 9'h021 ? lo : a == 12'h180 ? {nr[15:0], na[15:0]} : 0;
      if (pk && e3[0]) na++;
      else if (pk) nr++;
      if (op == 0)
        case (a)
          12'h100: hi |= d;
          12'h104: hi &= ~d;
          12'h108: lo |= d;
          12'h10C: lo &= ~d;
          default: ;
        endcase
    end
    end_sim();
  end
endmodule // tb_arnf_top
`default_nettype wire
